// ---- design/pbcap_pkg.sv ----
package pbcap_pkg;
    // Byte addresses on the APB port
    localparam logic [11:0] ADDR_ARB_PHASES = 12'h22c;
    localparam logic [11:0] ADDR_CAP_HEADER = 12'h280;
    localparam logic [11:0] ADDR_DATA_SELECT = 12'h284;
    localparam logic [11:0] ADDR_DATA_WINDOW = 12'h288;
    localparam logic [11:0] ADDR_SYS_ALLOC = 12'h28c;
    localparam logic [11:0] ADDR_WORD_BASE = 12'h300;
    localparam logic [11:0] ADDR_WORD_LAST = 12'h31c;
    localparam logic [11:0] ADDR_SW_CONTROL = 12'h404;

    // Field positions
    localparam int CAP_ID_LSB = 0;
    localparam int CAP_ID_W = 16;
    localparam int CAP_VER_LSB = 16;
    localparam int CAP_VER_W = 4;
    localparam int NEXT_PTR_LSB = 20;
    localparam int NEXT_PTR_W = 12;
    localparam int SELECT_W = 8;
    localparam int SYS_ALLOC_BIT = 0;
    localparam int UNLOCK_BIT = 3;
    localparam int SLOT_W = 4;
    localparam int NUM_SLOTS = 8;
    localparam int NUM_WORDS = 8;

    // Reset values
    localparam logic [31:0] RST_ARB_PHASES = 32'h4264_2642;
    localparam logic [31:0] RST_CAP_HEADER = 32'h0000_0000;
    localparam logic [7:0] RST_SELECT = 8'h00;
    localparam logic RST_SYS_ALLOC = 1'b0;
    localparam logic RST_UNLOCK = 1'b0;
    localparam logic [31:0] RST_BUDGET_WORD = 32'h0000_0000;

    // Values software is expected to load
    localparam logic [15:0] CAP_ID_POWER_BUDGET = 16'h0004;
    localparam logic [3:0] CAP_VER_ONE = 4'h1;

    // Port codes of the arbitration table
    localparam logic [3:0] PORT_UPSTREAM = 4'h0;
    localparam logic [3:0] PORT_DOWN_A = 4'h2;
    localparam logic [3:0] PORT_DOWN_B = 4'h4;
endpackage

// ---- design/pbcap_word_mux.sv ----
`timescale 1ns/10ps
// Data window selector: stored word for codes 0..7, zero for anything higher
module pbcap_word_mux #(
    parameter int NUM_WORDS = 8,
    parameter int SEL_W = 8
) (
    input wire logic [NUM_WORDS*32-1:0] words,
    input wire logic [SEL_W-1:0] select,
    output logic [31:0] window
);
    initial begin
        if (NUM_WORDS < 1 || NUM_WORDS > (1 << SEL_W))
            $error("pbcap_word_mux: NUM_WORDS out of range");
    end

    always_comb begin
        window = 32'h0000_0000; // see [R6]
        for (int i = 0; i < NUM_WORDS; i++) begin
            if (select == SEL_W'(i))
                window = words[i*32 +: 32]; // see [R5]
        end
    end
endmodule

// ---- design/pbcap_regs.sv ----
`timescale 1ns/10ps
// Summary of operation
// [R1] Phases 24 to 31: eight 4-bit read-write port slots, ascending nibbles.
// [R2] Header bits 15:0 hold capability identifier; value four means power budgeting.
// [R3] Header bits 19:16 version (one), bits 31:20 next capability pointer.
// [R4] Eight-bit read-write select chooses which stored budget word is shown.
// [R5] Select zero to seven: data window returns that stored budget word.
// [R6] Select above seven: data window reads all zeros.
// [R7] Bit zero of sys-alloc register: power already counted, ignore reported figures.
// [R8] Init agent should load header and sys-alloc bit from serial memory.
// [R9] Lockable fields accept writes only while global unlock bit is set.
// [R10] Eight consecutive 32-bit stored budget words feed the data window.
// [R11] Arbiter skips a phase naming an invalid port without spending a period.
// [R12] Reserved bits read zero, ignore writes; data window writes have no effect.
module pbcap_regs #(
    parameter int NUM_WORDS = pbcap_pkg::NUM_WORDS
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [31:0] arb_phase_table,
    output logic [7:0] arb_slot_valid,
    output logic system_allocated_flag,
    output logic global_write_unlock
);
    initial begin
        if (NUM_WORDS != pbcap_pkg::NUM_WORDS)
            $error("pbcap_regs: eight stored budget words are mapped");
    end

    logic [31:0] arb_phases_ff;
    logic [31:0] cap_header_ff;
    logic [7:0] budget_word_select_ff;
    logic system_allocated_ff;
    logic unlock_ff;
    logic [31:0] stored_budget_word_ff [NUM_WORDS];
    logic [NUM_WORDS*32-1:0] word_bus;
    logic [31:0] data_window;
    logic [31:0] nxt_prdata;
    logic [31:0] prdata_ff;
    logic wr_en;
    logic rd_en;
    logic hit;
    logic word_hit;
    logic [2:0] word_idx;

    // Zero-wait slave: every access completes in its first access cycle
    assign pready = 1'b1;
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;
    assign word_hit = (paddr >= pbcap_pkg::ADDR_WORD_BASE)
        && (paddr <= pbcap_pkg::ADDR_WORD_LAST) && (paddr[1:0] == 2'b00);
    assign word_idx = 3'((paddr - pbcap_pkg::ADDR_WORD_BASE) >> 2);

    always_comb begin
        hit = word_hit;
        unique case (paddr)
            pbcap_pkg::ADDR_ARB_PHASES,
            pbcap_pkg::ADDR_CAP_HEADER,
            pbcap_pkg::ADDR_DATA_SELECT,
            pbcap_pkg::ADDR_DATA_WINDOW,
            pbcap_pkg::ADDR_SYS_ALLOC,
            pbcap_pkg::ADDR_SW_CONTROL: hit = 1'b1;
            default: ;
        endcase
    end

    // Unmapped addresses answer with an error; writes there change nothing
    assign pslverr = psel & penable & ~hit;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            arb_phases_ff <= pbcap_pkg::RST_ARB_PHASES;
        end else if (wr_en && paddr == pbcap_pkg::ADDR_ARB_PHASES) begin
            arb_phases_ff <= pwdata; // see [R1]
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cap_header_ff <= pbcap_pkg::RST_CAP_HEADER;
        end else if (wr_en && unlock_ff && paddr == pbcap_pkg::ADDR_CAP_HEADER) begin
            // Whole header is lockable; id, version, pointer all take the write
            cap_header_ff[pbcap_pkg::CAP_ID_LSB +: pbcap_pkg::CAP_ID_W] <=
                pwdata[pbcap_pkg::CAP_ID_LSB +: pbcap_pkg::CAP_ID_W]; // see [R2] see [R9]
            cap_header_ff[pbcap_pkg::CAP_VER_LSB +: pbcap_pkg::CAP_VER_W] <=
                pwdata[pbcap_pkg::CAP_VER_LSB +: pbcap_pkg::CAP_VER_W]; // see [R3]
            cap_header_ff[pbcap_pkg::NEXT_PTR_LSB +: pbcap_pkg::NEXT_PTR_W] <=
                pwdata[pbcap_pkg::NEXT_PTR_LSB +: pbcap_pkg::NEXT_PTR_W]; // see [R3]
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            budget_word_select_ff <= pbcap_pkg::RST_SELECT;
        end else if (wr_en && paddr == pbcap_pkg::ADDR_DATA_SELECT) begin
            budget_word_select_ff <= pwdata[pbcap_pkg::SELECT_W-1:0]; // see [R4] see [R12]
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            system_allocated_ff <= pbcap_pkg::RST_SYS_ALLOC;
        end else if (wr_en && unlock_ff && paddr == pbcap_pkg::ADDR_SYS_ALLOC) begin
            system_allocated_ff <= pwdata[pbcap_pkg::SYS_ALLOC_BIT]; // see [R7] see [R9]
        end
    end

    // Unlock itself is never locked, else software could not reopen it
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            unlock_ff <= pbcap_pkg::RST_UNLOCK;
        end else if (wr_en && paddr == pbcap_pkg::ADDR_SW_CONTROL) begin
            unlock_ff <= pwdata[pbcap_pkg::UNLOCK_BIT];
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_WORDS; g++) begin : gen_word
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    stored_budget_word_ff[g] <= pbcap_pkg::RST_BUDGET_WORD;
                end else if (wr_en && unlock_ff && word_hit && word_idx == 3'(g)) begin
                    stored_budget_word_ff[g] <= pwdata; // see [R10] see [R9]
                end
            end
            assign word_bus[g*32 +: 32] = stored_budget_word_ff[g]; // see [R10]
        end
        for (g = 0; g < pbcap_pkg::NUM_SLOTS; g++) begin : gen_slot
            // Arbiter consumer skips a slot whose code is not a real port
            assign arb_slot_valid[g] =
                (arb_phases_ff[g*4 +: 4] == pbcap_pkg::PORT_UPSTREAM)
                || (arb_phases_ff[g*4 +: 4] == pbcap_pkg::PORT_DOWN_A)
                || (arb_phases_ff[g*4 +: 4] == pbcap_pkg::PORT_DOWN_B); // see [R11]
        end
    endgenerate

    pbcap_word_mux #(
        .NUM_WORDS(NUM_WORDS),
        .SEL_W(pbcap_pkg::SELECT_W)
    ) u_word_mux (
        .words(word_bus),
        .select(budget_word_select_ff),
        .window(data_window)
    );

    always_comb begin
        nxt_prdata = 32'h0000_0000; // see [R12]
        if (word_hit) begin
            nxt_prdata = stored_budget_word_ff[word_idx];
        end else begin
            unique case (paddr)
                pbcap_pkg::ADDR_ARB_PHASES: nxt_prdata = arb_phases_ff;
                pbcap_pkg::ADDR_CAP_HEADER: nxt_prdata = cap_header_ff;
                pbcap_pkg::ADDR_DATA_SELECT: nxt_prdata = {24'h000000, budget_word_select_ff};
                pbcap_pkg::ADDR_DATA_WINDOW: nxt_prdata = data_window; // see [R5] see [R6]
                pbcap_pkg::ADDR_SYS_ALLOC: nxt_prdata = {31'h0, system_allocated_ff};
                pbcap_pkg::ADDR_SW_CONTROL: nxt_prdata = {28'h0, unlock_ff, 3'b000};
                default: nxt_prdata = 32'h0000_0000;
            endcase
        end
    end

    // Read data is captured at the setup edge so it stands, registered, through
    // the zero-wait access cycle; a write always commits before the next setup
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata_ff <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata_ff <= nxt_prdata;
        end else if (!rd_en) begin
            prdata_ff <= 32'h0000_0000;
        end
    end

    assign prdata = prdata_ff;

    assign arb_phase_table = arb_phases_ff;
    assign system_allocated_flag = system_allocated_ff; // see [R7]
    assign global_write_unlock = unlock_ff;
endmodule

// ---- test/pbcap_regs_asserts.sv ----
`timescale 1ns/10ps
module pbcap_regs_chk #(
    parameter int NUM_WORDS = 8
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] arb_phase_table,
    input wire logic [7:0] arb_slot_valid,
    input wire logic system_allocated_flag,
    input wire logic global_write_unlock
);
    // Shadow of the select code, so window reads can be judged
    logic [7:0] sel_ff;
    wire rd = psel & penable & ~pwrite;
    wire wr = psel & penable & pwrite;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sel_ff <= 8'h00;
        end else if (wr && paddr == 12'h284) begin
            sel_ff <= pwdata[7:0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_table_write: assert property (wr && paddr == 12'h22c |=> arb_phase_table == $past(pwdata))
        else $error("phase table write lost");
    a_table_read: assert property (rd && paddr == 12'h22c |-> prdata == arb_phase_table)
        else $error("phase table read wrong");
    a_sel_read: assert property (rd && paddr == 12'h284 |-> prdata == {24'h0, sel_ff})
        else $error("select read wrong");
    a_window_zero: assert property (rd && paddr == 12'h288 && sel_ff > 8'h07 |-> prdata == 32'h0)
        else $error("window not zero");
    a_sa_locked: assert property (wr && paddr == 12'h28c && !global_write_unlock |=>
        $stable(system_allocated_flag)) else $error("locked flag changed");
    a_sa_unlocked: assert property (wr && paddr == 12'h28c && global_write_unlock |=>
        ($past(pwdata) & 32'h1) == {31'h0, system_allocated_flag}) else $error("flag write lost");
    a_sa_read: assert property (rd && paddr == 12'h28c |-> prdata == {31'h0, system_allocated_flag})
        else $error("flag read wrong");
    a_slot_valid: assert property (arb_slot_valid[7] == (arb_phase_table[31:28] inside {4'h0, 4'h2, 4'h4}))
        else $error("slot valid wrong");
endmodule
bind pbcap_regs pbcap_regs_chk #(.NUM_WORDS(NUM_WORDS)) u_chk (.clk(clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .arb_phase_table(arb_phase_table),
    .arb_slot_valid(arb_slot_valid), .system_allocated_flag(system_allocated_flag),
    .global_write_unlock(global_write_unlock));

// ---- test/pbcap_regs_test.sv ----
`timescale 1ns/10ps
module pbcap_regs_test;
    logic clk, reset_n, psel, penable, pwrite, pready, pslverr, e, m_ul;
    logic system_allocated_flag, global_write_unlock;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, arb_phase_table, r, m_arb, m_hdr, m_sa;
    logic [31:0] m_w [8];
    logic [7:0] arb_slot_valid, m_sel;
    logic [11:0] adr [7] = '{12'h22c, 12'h280, 12'h284, 12'h288, 12'h28c, 12'h300, 12'h3f0};
    int bad_count = 0, tests_run = 0, seed = 32'h410a;
    pbcap_regs dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .arb_phase_table(arb_phase_table), .arb_slot_valid(arb_slot_valid),
        .system_allocated_flag(system_allocated_flag), .global_write_unlock(global_write_unlock));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task check(input logic [31:0] s, input logic [31:0] x);
        tests_run++;
        if (s !== x) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, s, x);
        end
    endtask
    task finish_test;
        $display("%0d compared, %0d mismatched", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Zero-wait slave, but the access phase still waits for pready
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask
    task outs;
        logic [7:0] v;
        for (int i = 0; i < 8; i++) v[i] = m_arb[4*i +: 4] inside {4'h0, 4'h2, 4'h4};
        check(arb_phase_table, m_arb);
        check({24'h0, arb_slot_valid}, {24'h0, v});
        check({31'h0, system_allocated_flag}, m_sa);
        check({31'h0, global_write_unlock}, {31'h0, m_ul});
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        case (a)
            12'h22c: m_arb = d;
            12'h280: if (m_ul) m_hdr = d;
            12'h284: m_sel = d[7:0];
            12'h28c: if (m_ul) m_sa = d & 32'h1;
            12'h404: m_ul = d[3];
            default: if (m_ul && a >= 12'h300 && a <= 12'h31c) m_w[a[4:2]] = d;
        endcase
        outs();
    endtask
    task rd(input logic [11:0] a);
        logic [31:0] x;
        logic ee;
        ee = 1'b0;
        apb(1'b0, a, 32'h0);
        case (a)
            12'h22c: x = m_arb;
            12'h280: x = m_hdr;
            12'h284: x = {24'h0, m_sel};
            12'h288: x = (m_sel < 8) ? m_w[m_sel[2:0]] : 32'h0;
            12'h28c: x = m_sa;
            default: begin
                ee = !(a >= 12'h300 && a <= 12'h31c);
                x = ee ? 32'h0 : m_w[a[4:2]];
            end
        endcase
        check(r, x);
        check({31'h0, e}, {31'h0, ee});
    endtask
    initial begin
        logic [31:0] d;
        {reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {m_hdr, m_sel, m_sa, m_ul} = '0;
        m_arb = pbcap_pkg::RST_ARB_PHASES;
        foreach (m_w[i]) m_w[i] = 32'h0;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        foreach (adr[i]) rd(adr[i]);
        $display("test reset done");
        for (int k = 0; k < 2; k++) begin
            wr(12'h404, k ? 32'h8 : 32'h0);
            foreach (adr[i]) begin
                wr(adr[i], $random(seed));
                rd(adr[i]);
            end
            wr(12'h28c, 32'hffff_ffff);
            rd(12'h28c);
            $display("test write pass %0d done", k);
        end
        d = $random(seed);
        wr(12'h280, {d[11:0], pbcap_pkg::CAP_VER_ONE, pbcap_pkg::CAP_ID_POWER_BUDGET});
        rd(12'h280);
        wr(12'h22c, 32'h4204_2042);
        for (int i = 0; i < 8; i++) wr(12'h300 + 12'(4 * i), $random(seed));
        for (int s = 0; s < 10; s++) begin
            d = $random(seed);
            d[7:0] = (s < 8) ? 8'(s) : (s == 8 ? 8'h08 : 8'hff);
            wr(12'h284, d);
            rd(12'h284);
            rd(12'h288);
        end
        $display("test window done");
        wr(12'h404, 32'h0);
        wr(12'h28c, 32'h0);
        rd(12'h28c);
        $display("test relock done");
        finish_test;
    end
    initial begin
        #100000;
        bad_count++;
        finish_test;
    end
endmodule
